// >>> scp_pkg.sv
// constants shared by the configuration serial port slave
`default_nettype none
package scp_pkg;
  // ****************************************
  // link limits and timing
  // ****************************************
  localparam int SCLK_MAX_MHZ = 100;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [2:0] NIBBLE_LAST = 3'h3;
  localparam int ADDR_W = 15;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [14:0] CFG_ADDR = 15'h0000;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [14:0] TW_BASE_ADDR = 15'h0010;
  localparam int TW_BYTES = 6;
  localparam logic [14:0] TW_LOAD_ADDR = 15'h0016;
  localparam int TW_LOAD_BIT = 0;
  // ****************************************
  // serial_interface_config field positions
  // ****************************************
  localparam int CFG_SOFT_RESET = 7;
  localparam int CFG_LSB_FIRST = 6;
  localparam int CFG_STEP_UP = 5;
  localparam int CFG_SDO_ACTIVE = 4;
  localparam int CFG_SDO_ACTIVE_M = 3;
  localparam int CFG_STEP_UP_M = 2;
  localparam int CFG_LSB_FIRST_M = 1;
  localparam int CFG_SOFT_RESET_M = 0;
  // ****************************************
  // transfer phases
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA = 3'b100
  } scp_state_e;
endpackage : scp_pkg
`default_nettype wire

// >>> scp_reg_file.sv
// register storage with tuning word shadow and load
`default_nettype none
module scp_reg_file import scp_pkg::*; #(
  parameter int NUM_REGS = 32
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // write port
  input wire logic i_wr_en,
  input wire logic [14:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // read port
  input wire logic [14:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // register contents
  output logic [7:0] o_config,
  output logic [8*TW_BYTES-1:0] o_tuning_word
);
  // ****************************************
  // storage
  // ****************************************
  if (NUM_REGS <= int'(TW_LOAD_ADDR) || NUM_REGS > 256) begin : g_bad_depth
    $error("scp_reg_file: NUM_REGS must cover the tuning word load register");
  end

  logic [7:0] mem_reg [NUM_REGS];
  logic [7:0] mem_next [NUM_REGS];
  logic [8*TW_BYTES-1:0] tw_reg;
  logic [8*TW_BYTES-1:0] tw_next;
  logic [8*TW_BYTES-1:0] tw_shadow;
  logic load_req;

  // next contents on a write
  always_comb begin
    tw_shadow = '0;
    for (int i = 0; i < TW_BYTES; i++) begin
      tw_shadow[8*i +: 8] = mem_reg[int'(TW_BASE_ADDR) + i];
    end
    load_req = i_wr_en && i_wr_addr == TW_LOAD_ADDR && i_wr_data[TW_LOAD_BIT];
    for (int i = 0; i < NUM_REGS; i++) begin
      mem_next[i] = mem_reg[i];
      if (i_wr_en && i_wr_addr == 15'(i)) begin
        mem_next[i] = i_wr_data;
      end
    end
    // load request bit does not stick
    mem_next[int'(TW_LOAD_ADDR)][TW_LOAD_BIT] = 1'b0;
    // R18 - shadow moves on load
    tw_next = load_req ? tw_shadow : tw_reg;
  end

  // register the contents
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_reg[i] <= 8'h00;
      end
      mem_reg[0] <= CFG_RESET;
      tw_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      tw_reg <= tw_next;
    end
  end

  // read back, unmapped reads as zero
  always_comb begin
    o_rd_data = 8'h00;
    if (i_rd_addr < 15'(NUM_REGS)) begin
      o_rd_data = mem_reg[i_rd_addr[$clog2(NUM_REGS)-1:0]];
    end
  end
  assign o_config = mem_reg[0];
  assign o_tuning_word = tw_reg;

  // ****************************************
  // assertions
  // ****************************************
  logic [$clog2(NUM_REGS)-1:0] wr_idx;
  assign wr_idx = i_wr_addr[$clog2(NUM_REGS)-1:0];
  // R18 - byte lands next edge
  property p_write_lands;
    @(posedge i_clock) disable iff (!i_rst_b)
    i_wr_en && i_wr_addr < 15'(NUM_REGS) && i_wr_addr != TW_LOAD_ADDR
      |=> mem_reg[$past(wr_idx)] == $past(i_wr_data);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("byte write lost"); // R18
endmodule // scp_reg_file
`default_nettype wire

// >>> spi_config_port_slave.sv
// configuration serial port slave, top level
// ****************************************
// Summary of operation
// R1 - controller keeps serial clock at most 100 MHz
// R2 - bits captured on serial clock rise
// R3 - read bits change on serial clock fall
// R4 - activity ignored while chip select high
// R5 - data pin released while chip select high
// R6 - controller holds chip select low throughout
// R7 - mirrored bits 6 and 1 pick order
// R8 - msb first: flag, address, data descending
// R9 - lsb first: address, flag, data ascending
// R10 - output enable bits set: four wires
// R11 - output enable bits clear: shared pin
// R12 - each further byte uses next address
// R13 - bits 5 and 2 choose step direction
// R14 - chip select toggle restarts instruction phase
// R15 - config register write acts on first nibble
// R16 - sixteen rises instruction, then bytes of eight
// R17 - flag one reads, flag zero writes
// R18 - byte write lands at last bit
// R19 - shared pin driven during read data when output enable bits clear
// ****************************************
`default_nettype none
module spi_config_port_slave import scp_pkg::*; #(
  parameter int NUM_REGS = 32
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // serial port pins
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_sdo,
  // register contents toward the device
  output logic [7:0] o_serial_config,
  output logic [8*TW_BYTES-1:0] o_tuning_word
);
  // ****************************************
  // state
  // ****************************************
  scp_state_e state_reg, state_next;
  logic sclk_q_reg, sclk_q_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [2:0] data_cnt_reg, data_cnt_next;
  logic [15:0] instr_reg, instr_next;
  logic [7:0] data_reg, data_next;
  logic rw_reg, rw_next;
  logic [14:0] addr_reg, addr_next;
  logic sdo_reg, sdo_next;
  logic sdo_pin_reg, sdo_pin_next;
  logic oe_reg, oe_next;
  logic wr_en_reg, wr_en_next;
  logic [14:0] wr_addr_reg, wr_addr_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic [7:0] rd_data;
  logic [7:0] cfg;
  logic [15:0] ishift;
  logic [7:0] dshift;
  logic sclk_rise, sclk_fall, lsb_first, step_up, four_wire, rd_bit;

  // mirrored configuration pairs
  // R7 - either bit of pair
  assign lsb_first = cfg[CFG_LSB_FIRST] | cfg[CFG_LSB_FIRST_M];
  assign step_up = cfg[CFG_STEP_UP] | cfg[CFG_STEP_UP_M];
  assign four_wire = cfg[CFG_SDO_ACTIVE] | cfg[CFG_SDO_ACTIVE_M];
  // serial clock edges on the system clock
  assign sclk_rise = i_sclk & ~sclk_q_reg;
  assign sclk_fall = ~i_sclk & sclk_q_reg;
  assign rd_bit = lsb_first ? rd_data[data_cnt_reg] : rd_data[BYTE_LAST - data_cnt_reg];

  // ****************************************
  // transfer sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    sclk_q_next = i_sclk;
    bit_cnt_next = bit_cnt_reg;
    data_cnt_next = data_cnt_reg;
    instr_next = instr_reg;
    data_next = data_reg;
    rw_next = rw_reg;
    addr_next = addr_reg;
    sdo_next = sdo_reg;
    sdo_pin_next = sdo_pin_reg;
    oe_next = oe_reg;
    wr_en_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    // R8 R9 - shift direction per order
    ishift = lsb_first ? {i_sdio, instr_reg[15:1]} : {instr_reg[14:0], i_sdio};
    dshift = lsb_first ? {i_sdio, data_reg[7:1]} : {data_reg[6:0], i_sdio};
    if (i_cs_b) begin
      // R4 R5 R14 - idle and release
      state_next = ST_IDLE;
      bit_cnt_next = 4'h0;
      data_cnt_next = 3'h0;
      sdo_next = 1'b0;
      sdo_pin_next = 1'b0;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_INSTR: begin
          state_next = ST_INSTR;
          // R2 R16 - instruction bits on rises
          if (sclk_rise) begin
            instr_next = ishift;
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == INSTR_LAST) begin
              state_next = ST_DATA;
              // R17 - flag selects direction
              rw_next = ishift[15];
              addr_next = ishift[14:0];
              data_cnt_next = 3'h0;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            data_next = dshift;
            data_cnt_next = data_cnt_reg + 3'h1;
            // R15 - first nibble sets config
            if (!rw_reg && addr_reg == CFG_ADDR && data_cnt_reg == NIBBLE_LAST) begin
              wr_en_next = 1'b1;
              wr_addr_next = CFG_ADDR;
              wr_data_next = lsb_first ?
                {dshift[4], dshift[5], dshift[6], dshift[7], dshift[7:4]} :
                {dshift[3:0], dshift[0], dshift[1], dshift[2], dshift[3]};
            end
            if (data_cnt_reg == BYTE_LAST) begin
              // R18 - write at last bit
              if (!rw_reg && addr_reg != CFG_ADDR) begin
                wr_en_next = 1'b1;
                wr_addr_next = addr_reg;
                wr_data_next = dshift;
              end
              // R12 R13 - step address per byte
              addr_next = step_up ? addr_reg + 15'h0001 : addr_reg - 15'h0001;
            end
          end
          // R3 R10 R11 R19 - read bits on falls
          if (sclk_fall && rw_reg) begin
            sdo_next = rd_bit;
            sdo_pin_next = four_wire ? rd_bit : 1'b0;
            oe_next = !four_wire;
          end
        end
      endcase
    end
  end

  // register the sequencer
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
      sclk_q_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      data_cnt_reg <= 3'h0;
      instr_reg <= 16'h0000;
      data_reg <= 8'h00;
      rw_reg <= 1'b0;
      addr_reg <= 15'h0000;
      sdo_reg <= 1'b0;
      sdo_pin_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 15'h0000;
      wr_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      sclk_q_reg <= sclk_q_next;
      bit_cnt_reg <= bit_cnt_next;
      data_cnt_reg <= data_cnt_next;
      instr_reg <= instr_next;
      data_reg <= data_next;
      rw_reg <= rw_next;
      addr_reg <= addr_next;
      sdo_reg <= sdo_next;
      sdo_pin_reg <= sdo_pin_next;
      oe_reg <= oe_next;
      wr_en_reg <= wr_en_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // ****************************************
  // registers and pins
  // ****************************************
  scp_reg_file #(
    .NUM_REGS(NUM_REGS)
  ) u_regs (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_wr_en(wr_en_reg),
    .i_wr_addr(wr_addr_reg),
    .i_wr_data(wr_data_reg),
    .i_rd_addr(addr_reg),
    .o_rd_data(rd_data),
    .o_config(cfg),
    .o_tuning_word(o_tuning_word)
  );
  assign o_serial_config = cfg;
  assign o_sdio = sdo_reg;
  assign o_sdio_oe = oe_reg;
  assign o_sdo = sdo_pin_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  property p_release;
    i_cs_b |=> !o_sdio_oe && !o_sdio;
  endproperty
  a_release: assert property (p_release) else $error("data pin not released"); // R5
  property p_idle;
    i_cs_b |=> state_reg == ST_IDLE && bit_cnt_reg == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("chip select high not idle"); // R4
  property p_rise_only;
    state_reg == ST_INSTR && !sclk_rise && !i_cs_b |=> $stable(bit_cnt_reg);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("bit taken without rise"); // R2
  property p_fall_only;
    $changed(o_sdio) |-> $past(sclk_fall) || $past(i_cs_b);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("read bit moved off fall"); // R3
  property p_phase;
    state_reg == ST_INSTR && sclk_rise && bit_cnt_reg == INSTR_LAST && !i_cs_b
      |=> state_reg == ST_DATA && addr_reg == $past(ishift[14:0]);
  endproperty
  a_phase: assert property (p_phase) else $error("instruction not sixteen bits"); // R16
  property p_step;
    state_reg == ST_DATA && sclk_rise && data_cnt_reg == BYTE_LAST && !i_cs_b
      |=> addr_reg == ($past(step_up) ? $past(addr_reg) + 15'h0001 : $past(addr_reg) - 15'h0001);
  endproperty
  a_step: assert property (p_step) else $error("address step wrong"); // R12
  property p_mirror;
    cfg[CFG_LSB_FIRST] == cfg[CFG_LSB_FIRST_M] && cfg[CFG_STEP_UP] == cfg[CFG_STEP_UP_M]
      && cfg[CFG_SDO_ACTIVE] == cfg[CFG_SDO_ACTIVE_M];
  endproperty
  a_mirror: assert property (p_mirror) else $error("config pair not mirrored"); // R7
  property p_three_wire;
    state_reg == ST_DATA && rw_reg && sclk_fall && !i_cs_b && !four_wire
      |=> o_sdio_oe && !o_sdo;
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("shared pin not driven"); // R19
  property p_four_wire;
    o_sdio_oe |-> !$past(four_wire);
  endproperty
  a_four_wire: assert property (p_four_wire) else $error("shared pin driven in four wire"); // R10

  c_read: cover property (state_reg == ST_DATA && rw_reg && sclk_fall);
  c_write: cover property (wr_en_reg && wr_addr_reg != CFG_ADDR);
  c_cfg: cover property (wr_en_reg && wr_addr_reg == CFG_ADDR);
  c_multi: cover property (state_reg == ST_DATA && sclk_rise && data_cnt_reg == BYTE_LAST
    ##[1:200] state_reg == ST_DATA && sclk_rise && data_cnt_reg == BYTE_LAST);
endmodule // spi_config_port_slave
`default_nettype wire

// >>> scp_master.sv
// serial controller model that drives the configuration port
`default_nettype none
module scp_master (
  // clock
  input wire logic i_clock,
  // device side
  input wire logic i_line,
  input wire logic i_sdo,
  input wire logic i_sdio_oe,
  // controller pins
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_sdio,
  output logic o_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // pacing and byte buffers
  // ********
  int half = 4;
  logic [7:0] wd [8];
  logic [7:0] rd [8];
  logic oe_hit;
  logic sdo_hit;
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdio = 1'b0;
    o_drive = 1'b0;
  end
  // data set at fall, read taken before rise
  task automatic bit_x(input logic b, input logic four, output logic r);
    o_sclk <= 1'b0;
    o_sdio <= b;
    repeat (half) @(posedge i_clock);
    r = four ? i_sdo : i_line;
    oe_hit = oe_hit | i_sdio_oe;
    sdo_hit = sdo_hit | i_sdo;
    o_sclk <= 1'b1;
    repeat (half) @(posedge i_clock);
  endtask
  task automatic frame(input logic rw, input logic [14:0] a, input logic lsb,
      input logic four, input int nbits);
    logic [15:0] s;
    logic r;
    int k;
    s[0] = rw;
    for (int i = 0; i < 15; i++) s[15-i] = a[i];
    if (!lsb) s = {rw, a};
    oe_hit = 1'b0;
    sdo_hit = 1'b0;
    @(posedge i_clock);
    // chip select low for whole frame
    o_cs_b <= 1'b0;
    o_drive <= 1'b1;
    for (int i = 15; i >= 0; i--) bit_x(s[i], four, r);
    o_drive <= !rw;
    for (int j = 0; j < nbits; j++) begin
      k = lsb ? j % 8 : 7 - j % 8;
      bit_x(wd[j/8][k], four, r);
      rd[j/8][k] = r;
    end
    o_sclk <= 1'b0;
    repeat (half) @(posedge i_clock);
    o_cs_b <= 1'b1;
    o_drive <= 1'b0;
    repeat (half) @(posedge i_clock);
  endtask
  task automatic noise();
    o_drive <= 1'b1;
    o_sdio <= 1'b1;
    repeat (40) begin
      repeat (2) @(posedge i_clock);
      o_sclk <= ~o_sclk;
    end
    o_drive <= 1'b0;
  endtask
endmodule // scp_master
`default_nettype wire

// >>> spi_config_port_slave_bench.sv
// self-checking bench for the configuration serial port slave
`default_nettype none
module spi_config_port_slave_bench import scp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // clock, pins and instances
  // ********
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic junk = 1'b0;
  logic sclk, cs_b, m_sdio, drive, line, d_sdio, d_oe, d_sdo;
  logic [7:0] cfg;
  logic [47:0] tw;
  logic lsb = 1'b0;
  logic four = 1'b0;
  int miscompares = 0;
  int checked = 0;
  always #5 i_clock = ~i_clock;
  // floating shared line toggles every cycle
  always @(posedge i_clock) junk <= ~junk;
  assign line = d_oe ? d_sdio : (drive ? m_sdio : junk);
  spi_config_port_slave #(.NUM_REGS(32)) dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
    .i_sdio(line), .o_sdio(d_sdio), .o_sdio_oe(d_oe), .o_sdo(d_sdo),
    .o_serial_config(cfg), .o_tuning_word(tw));
  scp_master m (
    .i_clock(i_clock), .i_line(line), .i_sdo(d_sdo), .i_sdio_oe(d_oe),
    .o_sclk(sclk), .o_cs_b(cs_b), .o_sdio(m_sdio), .o_drive(drive));
  // compare and count
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one frame in the current mode, then let writes land
  task automatic xfer(input logic rw, input logic [14:0] a, input int n);
    m.frame(rw, a, lsb, four, 8 * n);
    repeat (4) @(posedge i_clock);
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    chk(cfg, CFG_RESET, "config reset");
    chk(d_oe, 1'b0, "pin released");
    chk(tw, '0, "tuning word reset");
  endtask
  task automatic t_burst_down();
    m.wd = '{8'ha5, 8'h3c, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    xfer(1'b0, 15'h0005, 3);
    xfer(1'b1, 15'h0005, 3);
    chk(m.rd[0], 8'ha5, "first byte");
    chk(m.rd[1], 8'h3c, "step down");
    chk(m.rd[2], 8'h81, "third byte");
    chk(m.oe_hit, 1'b1, "pin driven in read");
    chk(m.sdo_hit, 1'b0, "out pin unused");
    chk(d_oe, 1'b0, "pin released after frame");
  endtask
  task automatic t_four_wire();
    m.wd[0] = 8'h30;
    xfer(1'b0, CFG_ADDR, 1);
    chk(cfg, 8'h3c, "first nibble only");
    four = 1'b1;
    m.wd[0] = 8'h11;
    m.wd[1] = 8'h22;
    xfer(1'b0, 15'h0007, 2);
    xfer(1'b1, 15'h0007, 2);
    chk(m.rd[0], 8'h11, "separate out pin");
    chk(m.rd[1], 8'h22, "step up");
    chk(m.oe_hit, 1'b0, "shared pin idle");
  endtask
  task automatic t_lsb();
    m.wd[0] = 8'h60;
    xfer(1'b0, CFG_ADDR, 1);
    chk(cfg, 8'h66, "lsb first set");
    lsb = 1'b1;
    four = 1'b0;
    m.wd[0] = 8'h2d;
    m.wd[1] = 8'hc4;
    xfer(1'b0, 15'h000c, 2);
    xfer(1'b1, 15'h000c, 2);
    chk(m.rd[0], 8'h2d, "lsb byte");
    chk(m.rd[1], 8'hc4, "lsb next byte");
    m.wd[0] = 8'hf0;
    xfer(1'b0, CFG_ADDR, 1);
    lsb = 1'b0;
    chk(cfg, 8'h00, "lsb first nibble");
    xfer(1'b1, 15'h000c, 1);
    chk(m.rd[0], 8'h2d, "lsb write seen msb");
  endtask
  task automatic t_abort();
    m.wd[0] = 8'h5a;
    xfer(1'b0, 15'h000b, 1);
    m.noise();
    m.wd[0] = 8'hff;
    m.frame(1'b0, 15'h000b, lsb, four, 5);
    xfer(1'b1, 15'h000b, 1);
    chk(m.rd[0], 8'h5a, "partial byte dropped");
    chk(cfg, 8'h00, "noise ignored");
  endtask
  task automatic t_tuning();
    m.wd = '{8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11, 8'h00, 8'h00};
    xfer(1'b0, TW_LOAD_ADDR - 15'h0001, 6);
    chk(tw, '0, "shadow only");
    m.wd[0] = 8'h01;
    xfer(1'b0, TW_LOAD_ADDR, 1);
    chk(tw, 48'h665544332211, "tuning word loaded");
    xfer(1'b1, TW_LOAD_ADDR, 1);
    chk(m.rd[0], 8'h00, "load bit reads zero");
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clock);
    t_reset();
    t_burst_down();
    t_four_wire();
    t_lsb();
    t_abort();
    t_tuning();
    results();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge i_clock);
    miscompares++;
    results();
  end
endmodule // spi_config_port_slave_bench
`default_nettype wire
